// ---- src/startup_pkg.sv ----
// Constants and types shared by the clock source start-up timer
package startup_pkg;

   // ----------------------------------------
   // Register map, byte offsets
   // ----------------------------------------
   localparam logic [3:0] OFS_TRIM = 4'h0;
   localparam logic [3:0] OFS_STATUS = 4'h4;
   localparam logic [3:0] OFS_CONTROL = 4'h8;

   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int ST_HOLD = 0;
   localparam int ST_SLEEP = 1;
   localparam int ST_WDT = 2;
   localparam int ST_RSVD = 3;
   localparam int ST_CLASS = 4;
   localparam int ST_RANGE = 8;
   localparam int ST_WLEN = 11;
   localparam int ST_SOURCE = 16;
   localparam int CT_SLEEP = 0;

   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic [7:0] TRIM_RESET = 8'h00;
   // Source 0010, start-up 10, divide fuse programmed, reset pin fuse clear
   localparam logic [15:0] FUSE_RESET = 16'h2900;

   // ----------------------------------------
   // Fuse codes, 1 = unprogrammed
   // ----------------------------------------
   localparam logic [3:0] SRC_EXT = 4'h0;
   localparam logic [3:0] SRC_RC = 4'h2;
   localparam logic [3:0] SRC_PLL = 4'h3;
   localparam logic [1:0] SUT_RESERVED = 2'h3;

   // ----------------------------------------
   // Timing counts, in cycles
   // ----------------------------------------
   localparam logic [15:0] CK_6 = 16'h0006;
   localparam logic [15:0] CK_258 = 16'h0102;
   localparam logic [15:0] CK_1K = 16'h0400;
   localparam logic [15:0] CK_16K = 16'h4000;
   localparam logic [15:0] CK_FIXED = 16'h000E;
   localparam logic [16:0] WDT_4K = 17'h01000;
   localparam logic [16:0] WDT_64K = 17'h10000;
   localparam logic [2:0] PRESCALE_LAST = 3'h7;
   localparam logic [1:0] SETTLE_LAST = 2'h3;

   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef enum logic [1:0] {WDT_NONE, WDT_SHORT, WDT_LONG} wdt_len_t;
   typedef enum logic [2:0] {CLK_XTAL, CLK_PLL, CLK_RC, CLK_EXT, CLK_RSVD} clk_class_t;
   typedef struct packed {
      logic [15:0] wake_ck;
      wdt_len_t wdt;
      logic reserved;
   } startup_t;

endpackage

// ---- src/startup_wdt_if.sv ----
// Handshake between the start-up sequencer and the watchdog delay counter
`timescale 1ns/10ps
interface startup_wdt_if;
   logic start;
   startup_pkg::wdt_len_t len;
   logic busy;
   logic done;
   modport ctrl (output start, output len, input busy, input done);
   modport counter (input start, input len, output busy, output done);
endinterface

// ---- src/wdt_delay_counter.sv ----
// Reset time-out counted on watchdog oscillator edges
`timescale 1ns/10ps
module wdt_delay_counter #(
   parameter logic [16:0] SHORT_CYCLES = startup_pkg::WDT_4K,
   parameter logic [16:0] LONG_CYCLES = startup_pkg::WDT_64K
) (
   // Clock and reset
   input wire logic clock_i,
   input wire logic reset_i,
   // One pulse per watchdog oscillator cycle, already synchronised
   input wire logic wdt_tick_i,
   // Sequencer handshake
   startup_wdt_if.counter ctl
);

   logic [16:0] count;
   logic [16:0] target;
   logic last_tick;

   assign last_tick = ctl.busy && wdt_tick_i && (count == target - 17'h00001);

   // ----------------------------------------
   // Counter
   // ----------------------------------------
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         ctl.busy <= 1'b0;
         count <= 17'h00000;
         target <= SHORT_CYCLES;
      end else if (ctl.start) begin
         ctl.busy <= 1'b1;
         count <= 17'h00000;
         target <= (ctl.len == startup_pkg::WDT_LONG) ? LONG_CYCLES : SHORT_CYCLES;
      end else if (last_tick) begin
         ctl.busy <= 1'b0;
      end else if (ctl.busy && wdt_tick_i) begin
         count <= count + 17'h00001;
      end
   end

   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         ctl.done <= 1'b0;
      end else begin
         ctl.done <= last_tick && !ctl.start;
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   AST_WDT_FULL_COUNT: assert property (
      @(posedge clock_i) disable iff (reset_i)
      ctl.done |-> $past(count) == $past(target) - 17'h00001 && $past(wdt_tick_i))
      else $error("Delay ended before its full watchdog count");

   AST_WDT_NO_EARLY: assert property (
      @(posedge clock_i) disable iff (reset_i)
      ctl.busy && !wdt_tick_i |=> !ctl.done)
      else $error("Delay ended without a watchdog edge");

endmodule

// ---- src/clock_source_startup_timer.sv ----
// Clock source start-up sequencer with fuse decode, trim register and prescaler
// What this block does
// - A fuse bit at 1 is unprogrammed, at 0 programmed.
// - Wake from sleep counts selected-clock cycles before the core runs.
// - Reset start adds a delay counted on watchdog oscillator cycles.
// - Watchdog delay is 4,096 cycles (short) or 65,536 cycles (long).
// - Factory fuses: RC source 0010, start-up 10, divide-by-eight programmed.
// - Upper three source bits pick crystal range 100, 101, 110, 111.
// - Crystal, low bit 0: start-up codes map to 258 or 1K cycles.
// - Crystal, low bit 1: start-up codes map to 1K or 16K cycles.
// - Source code 0010 selects the internal RC oscillator.
// - Reset clears the trim register; the S_LOAD step then loads the factory calibration.
// - Software may rewrite the trim register after reset.
// - Reset time-out stays on the watchdog oscillator with RC selected.
// - RC source: 6 cycles on wake; reset adds 14, then no, short or long delay.
// - Reset-pin-disable programmed stretches RC codes 00 and 10 to short delay.
// - Divide-by-eight programmed divides the system clock by 8.
// - Source decode: 1xxx crystal, 0011 PLL, 0010 RC, 0000 external.
`timescale 1ns/10ps
module clock_source_startup_timer #(
   parameter logic [15:0] OSC_LONG_CK = startup_pkg::CK_16K,
   parameter logic [16:0] WDT_SHORT_CYCLES = startup_pkg::WDT_4K,
   parameter logic [16:0] WDT_LONG_CYCLES = startup_pkg::WDT_64K
) (
   // Clock and reset
   input wire logic clock_i,
   input wire logic reset_i,
   // Configuration fuses, 1 = unprogrammed
   input wire logic [3:0] clock_source_select_fuses_i,
   input wire logic [1:0] startup_time_fuses_i,
   input wire logic divide_by_eight_fuse_i,
   input wire logic reset_pin_disable_fuse_i,
   input wire logic [7:0] factory_calibration_i,
   // Oscillator and wake-up pins
   input wire logic wdt_osc_i,
   input wire logic wake_i,
   // Avalon-MM slave
   input wire logic [3:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   // Clock system outputs
   output logic cpu_hold_o,
   output logic sys_clock_enable_o,
   output logic [7:0] oscillator_trim_o,
   output logic [2:0] clock_class_o,
   output logic [2:0] crystal_range_select_bits_o,
   output logic sleeping_o
);

   typedef enum logic [2:0] {
      S_SETTLE, S_LOAD, S_OSC, S_FIXED, S_WDT, S_RUN, S_SLEEP, S_WAKE
   } seq_state_t;

   seq_state_t state;
   startup_pkg::startup_t cfg;
   startup_pkg::startup_t load_cfg;
   logic [15:0] ck_count;
   logic [1:0] settle;
   logic [15:0] fuse_meta;
   logic [15:0] fuse_sync;
   logic [1:0] pin_meta;
   logic [1:0] pin_sync;
   logic [1:0] pin_last;
   logic [3:0] source_select;
   logic [1:0] startup_time_code;
   logic div8_prog;
   logic rstdis_prog;
   logic wdt_tick;
   logic wake_tick;
   logic sleep_req;
   logic [2:0] prescale;
   logic [7:0] oscillator_trim_register;
   logic bus_req;
   logic bus_done;
   logic [31:0] status_word;
   logic [31:0] next_readdata;

   startup_wdt_if wdt ();

   // ----------------------------------------
   // Decode functions
   // ----------------------------------------
   function automatic startup_pkg::clk_class_t source_class(input logic [3:0] src);
      startup_pkg::clk_class_t c;
      c = startup_pkg::CLK_RSVD;
      if (src[3]) begin
         c = startup_pkg::CLK_XTAL;
      end else if (src == startup_pkg::SRC_PLL) begin
         c = startup_pkg::CLK_PLL;
      end else if (src == startup_pkg::SRC_RC) begin
         c = startup_pkg::CLK_RC;
      end else if (src == startup_pkg::SRC_EXT) begin
         c = startup_pkg::CLK_EXT;
      end
      return c;
   endfunction

   function automatic startup_pkg::startup_t decode_startup(
      input logic [3:0] src,
      input logic [1:0] startup_time_fuses,
      input logic rstdis
   );
      startup_pkg::startup_t d;
      startup_pkg::clk_class_t c;
      logic rc_stretch;
      c = source_class(src);
      rc_stretch = rstdis && (c == startup_pkg::CLK_RC);
      // Unsupported codes take the longest wait as the safe choice
      d.wake_ck = OSC_LONG_CK;
      d.wdt = startup_pkg::WDT_LONG;
      d.reserved = 1'b1;
      if (c == startup_pkg::CLK_XTAL) begin
         d.reserved = 1'b0;
         case ({src[0], startup_time_fuses})
            3'h0: d.wake_ck = startup_pkg::CK_258;
            3'h1: d.wake_ck = startup_pkg::CK_258;
            3'h2: d.wake_ck = startup_pkg::CK_1K;
            3'h3: d.wake_ck = startup_pkg::CK_1K;
            3'h4: d.wake_ck = startup_pkg::CK_1K;
            default: d.wake_ck = OSC_LONG_CK;
         endcase
         case ({src[0], startup_time_fuses})
            3'h0: d.wdt = startup_pkg::WDT_SHORT;
            3'h1: d.wdt = startup_pkg::WDT_LONG;
            3'h2: d.wdt = startup_pkg::WDT_NONE;
            3'h3: d.wdt = startup_pkg::WDT_SHORT;
            3'h4: d.wdt = startup_pkg::WDT_LONG;
            3'h5: d.wdt = startup_pkg::WDT_NONE;
            3'h6: d.wdt = startup_pkg::WDT_SHORT;
            default: d.wdt = startup_pkg::WDT_LONG;
         endcase
      end else if (c == startup_pkg::CLK_RC || c == startup_pkg::CLK_EXT) begin
         d.wake_ck = startup_pkg::CK_6;
         d.reserved = (startup_time_fuses == startup_pkg::SUT_RESERVED);
         case (startup_time_fuses)
            2'h0: d.wdt = rc_stretch ? startup_pkg::WDT_SHORT : startup_pkg::WDT_NONE;
            2'h1: d.wdt = startup_pkg::WDT_SHORT;
            2'h2: d.wdt = rc_stretch ? startup_pkg::WDT_SHORT : startup_pkg::WDT_LONG;
            default: d.wdt = startup_pkg::WDT_LONG;
         endcase
      end
      return d;
   endfunction

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   // Fuse flops start from the factory pattern so the first decode is sane
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         fuse_meta <= startup_pkg::FUSE_RESET;
         fuse_sync <= startup_pkg::FUSE_RESET;
         pin_meta <= 2'h0;
         pin_sync <= 2'h0;
         pin_last <= 2'h0;
      end else begin
         fuse_meta <= {clock_source_select_fuses_i, startup_time_fuses_i, divide_by_eight_fuse_i,
                       reset_pin_disable_fuse_i, factory_calibration_i};
         fuse_sync <= fuse_meta;
         pin_meta <= {wdt_osc_i, wake_i};
         pin_sync <= pin_meta;
         pin_last <= pin_sync;
      end
   end

   assign source_select = fuse_sync[15:12];
   assign startup_time_code = fuse_sync[11:10];
   assign div8_prog = ~fuse_sync[9];
   assign rstdis_prog = ~fuse_sync[8];
   // The watchdog oscillator times the delay whatever the system source
   assign wdt_tick = pin_sync[1] & ~pin_last[1];
   assign wake_tick = pin_sync[0] & ~pin_last[0];
   assign load_cfg = decode_startup(source_select, startup_time_code, rstdis_prog);

   // ----------------------------------------
   // Start-up sequencer
   // ----------------------------------------
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         state <= S_SETTLE;
         settle <= 2'h0;
         ck_count <= 16'h0000;
         cpu_hold_o <= 1'b1;
         cfg <= decode_startup(startup_pkg::FUSE_RESET[15:12], startup_pkg::FUSE_RESET[11:10], 1'b0);
         wdt.start <= 1'b0;
         wdt.len <= startup_pkg::WDT_NONE;
      end else begin
         wdt.start <= 1'b0;
         case (state)
            S_SETTLE: begin
               if (settle == startup_pkg::SETTLE_LAST) begin
                  state <= S_LOAD;
               end else begin
                  settle <= settle + 2'h1;
               end
            end
            S_LOAD: begin
               cfg <= load_cfg;
               ck_count <= load_cfg.wake_ck;
               state <= S_OSC;
            end
            S_OSC: begin
               if (ck_count == 16'h0001) begin
                  ck_count <= startup_pkg::CK_FIXED;
                  state <= S_FIXED;
               end else begin
                  ck_count <= ck_count - 16'h0001;
               end
            end
            S_FIXED: begin
               if (ck_count != 16'h0001) begin
                  ck_count <= ck_count - 16'h0001;
               end else if (cfg.wdt == startup_pkg::WDT_NONE) begin
                  state <= S_RUN;
                  cpu_hold_o <= 1'b0;
               end else begin
                  wdt.start <= 1'b1;
                  wdt.len <= cfg.wdt;
                  state <= S_WDT;
               end
            end
            S_WDT: begin
               if (wdt.done) begin
                  state <= S_RUN;
                  cpu_hold_o <= 1'b0;
               end
            end
            S_RUN: begin
               if (sleep_req) begin
                  state <= S_SLEEP;
                  cpu_hold_o <= 1'b1;
               end
            end
            S_SLEEP: begin
               if (wake_tick) begin
                  ck_count <= cfg.wake_ck;
                  state <= S_WAKE;
               end
            end
            S_WAKE: begin
               if (ck_count == 16'h0001) begin
                  state <= S_RUN;
                  cpu_hold_o <= 1'b0;
               end else begin
                  ck_count <= ck_count - 16'h0001;
               end
            end
            default: begin
               state <= S_SETTLE;
               cpu_hold_o <= 1'b1;
            end
         endcase
      end
   end

   wdt_delay_counter #(
      .SHORT_CYCLES(WDT_SHORT_CYCLES),
      .LONG_CYCLES(WDT_LONG_CYCLES)
   ) u_wdt (
      .clock_i(clock_i),
      .reset_i(reset_i),
      .wdt_tick_i(wdt_tick),
      .ctl(wdt.counter)
   );

   // ----------------------------------------
   // System clock prescaler
   // ----------------------------------------
   // Free running, so the divided enable keeps its phase through sleep
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         prescale <= 3'h0;
         sys_clock_enable_o <= 1'b0;
      end else begin
         prescale <= prescale + 3'h1;
         sys_clock_enable_o <= div8_prog ? (prescale == startup_pkg::PRESCALE_LAST) : 1'b1;
      end
   end

   // ----------------------------------------
   // Status outputs
   // ----------------------------------------
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         clock_class_o <= startup_pkg::CLK_RC;
         crystal_range_select_bits_o <= startup_pkg::FUSE_RESET[15:13];
         sleeping_o <= 1'b0;
      end else begin
         clock_class_o <= source_class(source_select);
         crystal_range_select_bits_o <= source_select[3:1];
         sleeping_o <= (state == S_SLEEP);
      end
   end

   // ----------------------------------------
   // Oscillator trim register
   // ----------------------------------------
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         oscillator_trim_register <= startup_pkg::TRIM_RESET;
      end else if (state == S_LOAD) begin
         oscillator_trim_register <= fuse_sync[7:0];
      end else if (bus_done && avs_write_i && avs_address_i == startup_pkg::OFS_TRIM && avs_byteenable_i[0]) begin
         oscillator_trim_register <= avs_writedata_i[7:0];
      end
   end

   assign oscillator_trim_o = oscillator_trim_register;

   // ----------------------------------------
   // Avalon-MM slave
   // ----------------------------------------
   // Every access takes one wait cycle; read data is captured with it
   assign bus_req = avs_read_i | avs_write_i;
   assign bus_done = bus_req & ~avs_waitrequest_o;

   always_comb begin
      status_word = 32'h00000000;
      status_word[startup_pkg::ST_HOLD] = cpu_hold_o;
      status_word[startup_pkg::ST_SLEEP] = (state == S_SLEEP);
      status_word[startup_pkg::ST_WDT] = wdt.busy;
      status_word[startup_pkg::ST_RSVD] = cfg.reserved;
      status_word[startup_pkg::ST_CLASS +: 3] = clock_class_o;
      status_word[startup_pkg::ST_RANGE +: 3] = crystal_range_select_bits_o;
      status_word[startup_pkg::ST_WLEN +: 2] = cfg.wdt;
      status_word[startup_pkg::ST_SOURCE +: 4] = source_select;
   end

   always_comb begin
      case (avs_address_i)
         startup_pkg::OFS_TRIM: next_readdata = {24'h000000, oscillator_trim_register};
         startup_pkg::OFS_STATUS: next_readdata = status_word;
         default: next_readdata = 32'h00000000;
      endcase
   end

   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         avs_waitrequest_o <= 1'b1;
         avs_readdata_o <= 32'h00000000;
      end else begin
         avs_waitrequest_o <= ~(bus_req & avs_waitrequest_o);
         if (avs_read_i && avs_waitrequest_o) begin
            avs_readdata_o <= next_readdata;
         end
      end
   end

   // Sleep request is a one-cycle pulse; ignored unless the core is running
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         sleep_req <= 1'b0;
      end else begin
         sleep_req <= bus_done && avs_write_i && avs_address_i == startup_pkg::OFS_CONTROL &&
                      avs_byteenable_i[0] && avs_writedata_i[startup_pkg::CT_SLEEP];
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking @(posedge clock_i);
   endclocking
   default disable iff (reset_i);

   AST_FUSE_POLARITY: assert property (
      fuse_sync[9] |=> sys_clock_enable_o)
      else $error("Unprogrammed divide fuse still divides");

   AST_DIV8_PERIOD: assert property (
      sys_clock_enable_o && !fuse_sync[9] && $past(!fuse_sync[9]) |=> !sys_clock_enable_o [*7])
      else $error("Divided clock enable not one in eight");

   AST_RESET_HOLD: assert property (
      $past(reset_i) |-> cpu_hold_o)
      else $error("Core released straight after reset");

   AST_RELEASE_AFTER_WDT: assert property (
      $fell(cpu_hold_o) && $past(state) == S_WDT |-> $past(wdt.done))
      else $error("Core released before the watchdog delay ended");

   AST_FIXED_14: assert property (
      state == S_OSC && ck_count == 16'h0001 |-> ##14 state == S_FIXED ##1 state != S_FIXED)
      else $error("Fixed reset part is not 14 cycles");

   AST_WAKE_LOAD: assert property (
      state == S_SLEEP && wake_tick |=> state == S_WAKE && ck_count == $past(cfg.wake_ck))
      else $error("Wake count not loaded from start-up setting");

   AST_RC_WAKE_SIX: assert property (
      state == S_SLEEP && wake_tick && clock_class_o == startup_pkg::CLK_RC
      |=> cpu_hold_o [*6] ##1 !cpu_hold_o)
      else $error("RC wake-up is not 6 cycles");

   AST_XTAL_LONG: assert property (
      state == S_LOAD && source_select[3] && source_select[0] && startup_time_code == 2'h1
      |=> cfg.wake_ck == OSC_LONG_CK && cfg.wdt == startup_pkg::WDT_NONE)
      else $error("Crystal code 1/01 decoded wrongly");

   AST_XTAL_258: assert property (
      state == S_LOAD && source_select[3] && !source_select[0] && startup_time_code == 2'h1
      |=> cfg.wake_ck == startup_pkg::CK_258 && cfg.wdt == startup_pkg::WDT_LONG)
      else $error("Crystal code 0/01 decoded wrongly");

   AST_RSTDIS_STRETCH: assert property (
      state == S_LOAD && source_select == startup_pkg::SRC_RC && rstdis_prog && startup_time_code == 2'h0
      |=> cfg.wdt == startup_pkg::WDT_SHORT)
      else $error("Reset-pin-disable did not stretch RC delay");

   AST_TRIM_LOAD: assert property (
      state == S_LOAD |=> oscillator_trim_o == $past(fuse_sync[7:0]))
      else $error("Factory calibration not loaded");

   AST_TRIM_WRITE: assert property (
      bus_done && avs_write_i && avs_address_i == startup_pkg::OFS_TRIM && avs_byteenable_i[0] && state != S_LOAD
      |=> oscillator_trim_o == $past(avs_writedata_i[7:0]))
      else $error("Trim register write lost");

   AST_XTAL_RANGE: assert property (
      source_select[3] |=> crystal_range_select_bits_o == $past(source_select[3:1]))
      else $error("Crystal range bits not passed on");

endmodule

// ---- bench/test_clock_source_startup_timer.sv ----
// Self-checking bench for the clock source start-up timer
`timescale 1ns/10ps
module test_clock_source_startup_timer;
   // ----------------------------------------
   // Stimulus, observed outputs, case table
   // ----------------------------------------
   logic clock_i = 1'b0, reset_i = 1'b1, div = 1'b0, rstdis = 1'b1, wdt_osc = 1'b0, wake = 1'b0;
   logic rd = 1'b0, wr = 1'b0, wait_o, hold, clk_en, sleeping;
   logic [3:0] src = 4'h2, addr = 4'h0;
   logic [1:0] startup_time_fuses = 2'h2;
   logic [2:0] wcnt = 3'h0, cls, range;
   logic [7:0] cal = 8'h00, trim;
   logic [31:0] wdata = 32'h0, rdata, q;
   int fails = 0, n_checks = 0, t, lo, n;
   // Nibbles: source, start-up code, pin fuse, divide fuse, class, delay length, reserved
   // Crystal rows stand for a ceramic resonator, so range 100 stays unused
   // and the 258-cycle codes are fair to use
   logic [31:0] tab[10] = '{32'h2210_2200, 32'h2001_2100, 32'h2110_2100, 32'hE011_0100,
                            32'hE210_0000, 32'hF111_0000, 32'hF310_0200, 32'h0211_3200,
                            32'hE111_0200, 32'h2310_2210};
   // Wake counts; 32 stands for the shortened long crystal count
   int n_tab[10] = '{6, 6, 6, 258, 1024, 32, 32, 6, 258, 6};

   always #2 clock_i = ~clock_i;
   // Watchdog oscillator at one eighth of the system clock
   always @(posedge clock_i) begin
      wcnt <= wcnt + 3'h1;
      wdt_osc <= wcnt[2];
   end

   clock_source_startup_timer #(.OSC_LONG_CK(16'h0020), .WDT_SHORT_CYCLES(17'h00008),
      .WDT_LONG_CYCLES(17'h00010)) dut (.clock_i(clock_i), .reset_i(reset_i),
      .clock_source_select_fuses_i(src), .startup_time_fuses_i(startup_time_fuses), .divide_by_eight_fuse_i(div),
      .reset_pin_disable_fuse_i(rstdis), .factory_calibration_i(cal), .wdt_osc_i(wdt_osc),
      .wake_i(wake), .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
      .avs_writedata_i(wdata), .avs_byteenable_i(4'hF), .avs_readdata_o(rdata),
      .avs_waitrequest_o(wait_o), .cpu_hold_o(hold), .sys_clock_enable_o(clk_en),
      .oscillator_trim_o(trim), .clock_class_o(cls), .crystal_range_select_bits_o(range),
      .sleeping_o(sleeping));

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Request held until waitrequest is sampled low, data taken at that edge
   task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge clock_i);
      rd <= !w;
      wr <= w;
      addr <= a;
      wdata <= d;
      // No local limit: only the watchdog may end a stuck access
      do begin
         @(posedge clock_i);
      end while (wait_o !== 1'b0);
      q = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask

   task hold_wait(output int c);
      c = 0;
      do begin
         @(posedge clock_i);
         c++;
      end while (hold !== 1'b0 && c < 5000);
   endtask

   task wrap_up;
      $display("checks %0d, mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   initial begin
      #200000;
      fails++;
      wrap_up;
   end

   // ----------------------------------------
   // One reset, register and sleep pass per fuse setting
   // ----------------------------------------
   initial begin
      for (int i = 0; i < 10; i++) begin
         @(posedge clock_i);
         src <= tab[i][31:28];
         startup_time_fuses <= tab[i][25:24];
         rstdis <= tab[i][20];
         div <= tab[i][16];
         cal <= 8'h3C + 8'(i);
         reset_i <= 1'b1;
         repeat (10) @(posedge clock_i);
         chk({wait_o, hold, clk_en, trim}, {3'b110, 8'h00});
         reset_i <= 1'b0;
         lo = n_tab[i] + 11 + 64 * int'(tab[i][11:8]);
         hold_wait(t);
         chk(32'(t >= lo && t <= lo + 30), 32'h1);
         bus(1'b0, startup_pkg::OFS_STATUS, 32'h0);
         chk(q & 32'h000F_1F7F, {12'h0, src, 3'h0, tab[i][9:8], src[3:1], 1'b0, tab[i][14:12], tab[i][4], 3'h0});
         chk({cls, range}, {tab[i][14:12], src[3:1]});
         bus(1'b0, startup_pkg::OFS_TRIM, 32'h0);
         chk(q, {24'h0, cal});
         bus(1'b1, startup_pkg::OFS_TRIM, 32'h5A + 32'(i));
         bus(1'b0, startup_pkg::OFS_TRIM, 32'h0);
         chk(q, 32'h5A + 32'(i));
         chk(32'(trim), 32'h5A + 32'(i));
         bus(1'b0, 4'hC, 32'h0);
         chk(q, 32'h0);
         n = 0;
         repeat (32) begin
            @(posedge clock_i);
            n += int'(clk_en);
         end
         chk(32'(n), div ? 32'h20 : 32'h4);
         bus(1'b1, startup_pkg::OFS_CONTROL, 32'h1);
         t = 0;
         while (sleeping !== 1'b1 && t < 20) begin
            @(posedge clock_i);
            t++;
         end
         chk({sleeping, hold}, 2'b11);
         wake <= 1'b1;
         hold_wait(t);
         chk(32'(t >= n_tab[i] && t <= n_tab[i] + 8), 32'h1);
         wake <= 1'b0;
      end
      wrap_up;
   end
endmodule
